// File: shared/rfc_regs.svh
/*
  register indices, field positions, reset values and timing figures of the
  framing and wait-timing configuration block.
  assumes one aligned 32-bit word per register, byte address = index * 4.
*/
`ifndef RFC_REGS_SVH
`define RFC_REGS_SVH

// register indices
`define RFC_IDX_WAIT_CTRL   8'h31
`define RFC_IDX_WAIT_LOW    8'h32
`define RFC_IDX_FRAME_CTL   8'h33
`define RFC_IDX_START_DET   8'h34
`define RFC_IDX_RX_CTL      8'h35
`define RFC_IDX_MODE        8'h40

// reset values
`define RFC_WAIT_CTRL_RST   8'hc0
`define RFC_REG_RST         8'h00

// tx_wait_control fields
`define RFC_WC_ORIGIN       7
`define RFC_WC_UNIT         6
`define RFC_WC_HIGH_MSB     5
`define RFC_WC_HIGH_LSB     3
`define RFC_WC_STOP_MSB     2
`define RFC_WC_STOP_LSB     0

// frame_control fields
`define RFC_FC_TX_PARITY    7
`define RFC_FC_RX_PARITY    6
`define RFC_FC_TRAIL_MSB    3
`define RFC_FC_TRAIL_LSB    2
`define RFC_FC_LEAD_MSB     1
`define RFC_FC_LEAD_LSB     0

// rx_start_detect fields
`define RFC_SD_SOF_EN       5
`define RFC_SD_SOF_SEEN     4
`define RFC_SD_SUB_EN       2
`define RFC_SD_SUB_SEEN     1
`define RFC_SD_SUB_LIVE     0

// rx_control fields
`define RFC_RC_PARTIAL      7
`define RFC_RC_CONTINUOUS   6
`define RFC_RC_EOF_TYPE_B   5
`define RFC_RC_GUARD_CHECK  4
`define RFC_RC_DISTURB      3
`define RFC_RC_RATE_MSB     2
`define RFC_RC_RATE_LSB     0

// mode register fields
`define RFC_MD_TYPE_B       0
`define RFC_MD_BUSY         7

// stop, guard, rate and disturbance coding
`define RFC_STOP_NONE       3'h0
`define RFC_STOP_ONE        3'h1
`define RFC_RATE_LOWEST     3'h4
`define RFC_DISTURB_BYTES   2'd3

// bus answers
`define RFC_RESP_OKAY       2'b00
`define RFC_RESP_SLVERR     2'b10

// wait unit: 16 carrier periods of 13.56 MHz on a 20 MHz clock, rounded up
`define RFC_CARRIER_UNIT    16
`define RFC_CARRIER_KHZ     13560
`define RFC_CLK_KHZ         20000
`define RFC_CARRIER_UNIT_CYC ((`RFC_CARRIER_UNIT * `RFC_CLK_KHZ + `RFC_CARRIER_KHZ - 1) / `RFC_CARRIER_KHZ)

`endif

// File: shared/rfc_pkg.sv
/*
  types shared by the framing configuration block and its wait timer.
  assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none

package rfc_pkg;

  typedef enum logic [1:0] {
    WAIT_IDLE = 2'b01,
    WAIT_RUN  = 2'b10
  } rfc_wait_e;

  typedef struct packed {
    logic       parityAppend;
    logic [1:0] leaderSymbol;
    logic [1:0] trailerSymbol;
    logic       stopBit;
    logic [2:0] guardTimes;
  } rfc_tx_cfg_s;

  typedef struct packed {
    logic       parityCheck;
    logic       continuous;
    logic       eofTypeB;
    logic       eofCheck;
    logic       rateValid;
    logic [1:0] rateSel;
  } rfc_rx_cfg_s;

  typedef struct packed {
    logic [7:0] data;
    logic       parity;
    logic       complete;
  } rfc_rx_byte_s;

  typedef struct packed {
    logic [7:0] waitCtrl;
    logic [7:0] waitLow;
    logic [7:0] frameCtl;
    logic [7:0] rxCtl;
    logic       sofEn;
    logic       sofSeen;
    logic       subEn;
    logic       subSeen;
    logic       typeB;
    logic       bvalid;
    logic [1:0] bresp;
    logic       rvalid;
    logic [1:0] rresp;
    logic [7:0] rdata;
    logic [1:0] byteCount;
    logic       suppressed;
    logic       fifoWrite;
    logic [7:0] fifoData;
    logic       fifoFlush;
    logic       protoErr;
    logic       rxDone;
    logic       rxAutoStop;
    logic       txParity;
  } rfc_main_state_s;

endpackage

`default_nettype wire

// File: rtl/rfc_wait_timer.sv
/*
  wait timer: counts a programmed number of wait units after a start pulse.
  assumes halfBitTick is a one-cycle pulse on clk, one per half bit period.
*/
`default_nettype none
`include "rfc_regs.svh"

module rfc_wait_timer #(
  parameter int WAIT_W   = 11,
  parameter int UNIT_CYC = `RFC_CARRIER_UNIT_CYC
) (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  // control
  input  wire logic              start,
  input  wire logic [WAIT_W-1:0] waitValue,
  input  wire logic              halfBitUnit,
  input  wire logic              halfBitTick,
  // status
  output logic                   busy
);
  import rfc_pkg::*;

  localparam int PRE_W = $clog2(UNIT_CYC + 1);

  generate
    if (UNIT_CYC < 1 || WAIT_W < 1)
    begin : g_bad
      $error("wait timer needs a unit of one cycle or more");
    end
  endgenerate

  typedef struct packed {
    rfc_wait_e         phase;
    logic [WAIT_W-1:0] remain;
    logic [PRE_W-1:0]  pre;
  } rfc_timer_state_s;

  rfc_timer_state_s stateReg;
  rfc_timer_state_s stateNext;
  logic             unitTick;

  // carrier units come from the prescaler, half-bit units from the bit clock
  assign unitTick = halfBitUnit ? halfBitTick
                  : (stateReg.pre == PRE_W'(UNIT_CYC - 1));

  always_comb
  begin
    stateNext = stateReg;
    if (start)
    begin
      stateNext.remain = waitValue;
      stateNext.pre    = '0;
      stateNext.phase  = (waitValue == '0) ? WAIT_IDLE : WAIT_RUN;
    end
    else
    begin
      unique case (stateReg.phase)
        WAIT_IDLE:
        begin
          stateNext.pre = '0;
        end
        WAIT_RUN:
        begin
          stateNext.pre = (unitTick || halfBitUnit) ? '0 : stateReg.pre + 1'b1;
          if (unitTick)
          begin
            stateNext.remain = stateReg.remain - 1'b1;
            if (stateReg.remain == WAIT_W'(1))
            begin
              stateNext.phase = WAIT_IDLE;
            end
          end
        end
        default:
        begin
          stateNext.phase = WAIT_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      stateReg.phase  <= WAIT_IDLE;
      stateReg.remain <= '0;
      stateReg.pre    <= '0;
    end
    else
    begin
      stateReg <= stateNext;
    end
  end

  assign busy = (stateReg.phase == WAIT_RUN);

  a_unit_length: assert property (@(posedge clk) disable iff (rst)
    (start && !halfBitUnit && waitValue == WAIT_W'(1)) |=> busy[*2])
    else $error("carrier wait unit ended too early");

endmodule // rfc_wait_timer

`default_nettype wire

// File: rtl/rfc_frame_timing.sv
/*
  framing and wait-timing configuration of the contactless transceiver, with
  an AXI4-Lite register slave, the transmit wait gate and receive-side FIFO
  write control.
  assumes tx and rx engines on the same clock, giving one-cycle pulses.
// Operation
// - wait starts at tx end or rx end
// - wait unit: 16 carrier periods or half bit
// - wait value: low byte plus three high bits
// - keep programmed wait before each transmission
// - type B stop bit and guard times code
// - append computed parity to each sent byte
// - check rx parity, never store parity bits
// - trailing symbol chosen by two-bit field
// - leading symbol chosen by two-bit field
// - frame start raises interrupt when enabled
// - sticky frame-start flag, software clears it
// - subcarrier raises same interrupt when enabled
// - sticky subcarrier flag, software clears it
// - live bit shows subcarrier present now
// - partial-byte store writes incomplete bytes anyway
// - continuous receive never stops automatically
// - continuous receive appends error byte per frame
// - frame-end style picks type B or symbol
// - style zero with symbols zero disables check
// - wait control resets to c0
// - guard check flags overlong type B guard
// - early error discards bytes, flushes, no irq
// - rate field codes four to seven valid
*/
// Implementation choice: the AXI4-Lite register port.
`default_nettype none
`include "rfc_regs.svh"

module rfc_frame_timing #(
  parameter int WAIT_W   = 11,
  parameter int UNIT_CYC = `RFC_CARRIER_UNIT_CYC
) (
  // clock and reset
  input  wire logic            clk,
  input  wire logic            rst,
  // register bus
  input  wire logic [11:0]     awaddr,
  input  wire logic            awvalid,
  output logic                 awready,
  input  wire logic [31:0]     wdata,
  input  wire logic [3:0]      wstrb,
  input  wire logic            wvalid,
  output logic                 wready,
  output logic [1:0]           bresp,
  output logic                 bvalid,
  input  wire logic            bready,
  input  wire logic [11:0]     araddr,
  input  wire logic            arvalid,
  output logic                 arready,
  output logic [31:0]          rdata,
  output logic [1:0]           rresp,
  output logic                 rvalid,
  input  wire logic            rready,
  // transmit engine
  input  wire logic            txRequest,
  output logic                 txGrant,
  input  wire logic            txFrameEnd,
  input  wire logic [7:0]      txByte,
  input  wire logic            txByteValid,
  output logic                 txParityBit,
  output rfc_pkg::rfc_tx_cfg_s txCfg,
  input  wire logic            halfBitTick,
  // receive engine
  input  wire logic            sofDetect,
  input  wire logic            subcarrierLive,
  input  wire logic            crcEnable,
  input  wire logic            rxByteValid,
  input  wire rfc_pkg::rfc_rx_byte_s rxByte,
  input  wire logic            rxError,
  input  wire logic            rxFrameEnd,
  input  wire logic            rxGuardTooLong,
  input  wire logic [7:0]      errorReg,
  input  wire logic [1:0]      endSymbolBits,
  output rfc_pkg::rfc_rx_cfg_s rxCfg,
  // fifo and events
  output logic                 fifoWrite,
  output logic [7:0]           fifoData,
  output logic                 fifoFlush,
  output logic                 rxDone,
  output logic                 rxAutoStop,
  output logic                 protoErr,
  output logic                 frameStartIrq
);
  import rfc_pkg::*;

  generate
    if (WAIT_W != 11)
    begin : g_bad
      $error("wait value is eleven bits wide");
    end
  endgenerate

  rfc_main_state_s   stateReg;
  rfc_main_state_s   stateNext;
  logic              timerBusy;
  logic              waitStart;
  logic [WAIT_W-1:0] waitValue;
  logic              wrFire;
  logic              wrOk;
  logic [7:0]        wrIdx;
  logic              rdFire;
  logic              rdOk;
  logic              parityBad;
  logic              frameErr;
  logic              disturbHit;
  logic              storeByte;

  function automatic logic idxMapped(input logic [11:0] addr);
    logic [7:0] idx;
    idx = addr[9:2];
    idxMapped = (addr[11:10] == 2'b00) && (addr[1:0] == 2'b00) &&
                (idx == `RFC_IDX_WAIT_CTRL || idx == `RFC_IDX_WAIT_LOW ||
                 idx == `RFC_IDX_FRAME_CTL || idx == `RFC_IDX_START_DET ||
                 idx == `RFC_IDX_RX_CTL    || idx == `RFC_IDX_MODE);
  endfunction

  assign wrIdx  = awaddr[9:2];
  assign wrOk   = idxMapped(awaddr);
  assign rdOk   = idxMapped(araddr);
  // both channels are taken together; a lone address or data waits
  assign wrFire = awvalid && wvalid && !stateReg.bvalid;
  assign rdFire = arvalid && !stateReg.rvalid;

  // wait value and origin event
  assign waitValue = {stateReg.waitCtrl[`RFC_WC_HIGH_MSB:`RFC_WC_HIGH_LSB],
                      stateReg.waitLow};
  assign waitStart = stateReg.waitCtrl[`RFC_WC_ORIGIN] ? rxFrameEnd
                   : txFrameEnd;

  rfc_wait_timer #(
    .WAIT_W   (WAIT_W),
    .UNIT_CYC (UNIT_CYC)
  ) u_wait (
    .clk         (clk),
    .rst         (rst),
    .start       (waitStart),
    .waitValue   (waitValue),
    .halfBitUnit (stateReg.waitCtrl[`RFC_WC_UNIT]),
    .halfBitTick (halfBitTick),
    .busy        (timerBusy)
  );

  // a request in the origin cycle is held too, since the count is not loaded
  assign txGrant = txRequest && !timerBusy && !waitStart;

  // receive byte classification
  assign parityBad  = stateReg.frameCtl[`RFC_FC_RX_PARITY] &&
                      (rxByte.parity != ~^rxByte.data);
  assign frameErr   = parityBad || rxError;
  assign disturbHit = rxByteValid && frameErr &&
                      stateReg.rxCtl[`RFC_RC_DISTURB] &&
                      (stateReg.byteCount < `RFC_DISTURB_BYTES);
  assign storeByte  = rxByte.complete || !crcEnable ||
                      stateReg.rxCtl[`RFC_RC_PARTIAL];

  always_comb
  begin
    stateNext = stateReg;
    stateNext.fifoWrite  = 1'b0;
    stateNext.fifoFlush  = 1'b0;
    stateNext.rxDone     = 1'b0;
    stateNext.rxAutoStop = 1'b0;
    stateNext.protoErr   = 1'b0;
    // write channel
    if (stateReg.bvalid && bready)
    begin
      stateNext.bvalid = 1'b0;
    end
    if (wrFire)
    begin
      stateNext.bvalid = 1'b1;
      stateNext.bresp  = wrOk ? `RFC_RESP_OKAY : `RFC_RESP_SLVERR;
      if (wrOk && wstrb[0])
      begin
        case (wrIdx)
          `RFC_IDX_WAIT_CTRL: stateNext.waitCtrl = wdata[7:0];
          `RFC_IDX_WAIT_LOW:  stateNext.waitLow  = wdata[7:0];
          `RFC_IDX_FRAME_CTL: stateNext.frameCtl = wdata[7:0];
          `RFC_IDX_RX_CTL:    stateNext.rxCtl    = wdata[7:0];
          `RFC_IDX_MODE:      stateNext.typeB    = wdata[`RFC_MD_TYPE_B];
          `RFC_IDX_START_DET:
          begin
            stateNext.sofEn   = wdata[`RFC_SD_SOF_EN];
            stateNext.subEn   = wdata[`RFC_SD_SUB_EN];
            // writing zero clears a sticky flag, writing one keeps it
            stateNext.sofSeen = stateReg.sofSeen & wdata[`RFC_SD_SOF_SEEN];
            stateNext.subSeen = stateReg.subSeen & wdata[`RFC_SD_SUB_SEEN];
          end
          default: stateNext.typeB = stateReg.typeB;
        endcase
      end
    end
    // detection wins over a clear in the same cycle
    if (sofDetect)
    begin
      stateNext.sofSeen = 1'b1;
    end
    if (subcarrierLive)
    begin
      stateNext.subSeen = 1'b1;
    end
    // read channel
    if (stateReg.rvalid && rready)
    begin
      stateNext.rvalid = 1'b0;
    end
    if (rdFire)
    begin
      stateNext.rvalid = 1'b1;
      stateNext.rresp  = rdOk ? `RFC_RESP_OKAY : `RFC_RESP_SLVERR;
      stateNext.rdata  = `RFC_REG_RST;
      if (rdOk)
      begin
        case (araddr[9:2])
          `RFC_IDX_WAIT_CTRL: stateNext.rdata = stateReg.waitCtrl;
          `RFC_IDX_WAIT_LOW:  stateNext.rdata = stateReg.waitLow;
          `RFC_IDX_FRAME_CTL: stateNext.rdata = stateReg.frameCtl;
          `RFC_IDX_RX_CTL:    stateNext.rdata = stateReg.rxCtl;
          `RFC_IDX_START_DET:
          begin
            stateNext.rdata[`RFC_SD_SOF_EN]   = stateReg.sofEn;
            stateNext.rdata[`RFC_SD_SOF_SEEN] = stateReg.sofSeen;
            stateNext.rdata[`RFC_SD_SUB_EN]   = stateReg.subEn;
            stateNext.rdata[`RFC_SD_SUB_SEEN] = stateReg.subSeen;
            stateNext.rdata[`RFC_SD_SUB_LIVE] = subcarrierLive;
          end
          default:
          begin
            stateNext.rdata[`RFC_MD_TYPE_B] = stateReg.typeB;
            stateNext.rdata[`RFC_MD_BUSY]   = timerBusy;
          end
        endcase
      end
    end
    // transmit parity, odd over the byte
    if (txByteValid)
    begin
      stateNext.txParity = ~^txByte;
    end
    // receive bytes; only the eight data bits reach the fifo
    if (disturbHit)
    begin
      stateNext.fifoFlush  = 1'b1;
      stateNext.suppressed = 1'b1;
      stateNext.byteCount  = '0;
    end
    else if (rxByteValid)
    begin
      stateNext.fifoWrite = storeByte;
      stateNext.fifoData  = rxByte.data;
      if (stateReg.byteCount != `RFC_DISTURB_BYTES)
      begin
        stateNext.byteCount = stateReg.byteCount + 1'b1;
      end
    end
    // frame end; assumed never in the same cycle as a received byte
    if (rxFrameEnd)
    begin
      stateNext.byteCount  = '0;
      stateNext.suppressed = 1'b0;
      stateNext.rxDone     = !stateReg.suppressed && !(
                             stateReg.rxCtl[`RFC_RC_DISTURB] &&
                             stateReg.byteCount < `RFC_DISTURB_BYTES);
      if (stateReg.rxCtl[`RFC_RC_CONTINUOUS])
      begin
        stateNext.fifoWrite = 1'b1;
        stateNext.fifoData  = errorReg;
      end
      else
      begin
        stateNext.rxAutoStop = 1'b1;
      end
    end
    stateNext.protoErr = rxGuardTooLong && stateReg.typeB &&
                         stateReg.rxCtl[`RFC_RC_GUARD_CHECK];
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      stateReg          <= '0;
      stateReg.waitCtrl <= `RFC_WAIT_CTRL_RST;
    end
    else
    begin
      stateReg <= stateNext;
    end
  end

  // bus outputs
  assign awready = wrFire;
  assign wready  = wrFire;
  assign bvalid  = stateReg.bvalid;
  assign bresp   = stateReg.bresp;
  assign arready = rdFire;
  assign rvalid  = stateReg.rvalid;
  assign rresp   = stateReg.rresp;
  assign rdata   = {24'h000000, stateReg.rdata};

  // transmit configuration; stop and guard only apply to type B
  assign txParityBit         = stateReg.txParity;
  assign txCfg.parityAppend  = stateReg.frameCtl[`RFC_FC_TX_PARITY];
  assign txCfg.trailerSymbol =
    stateReg.frameCtl[`RFC_FC_TRAIL_MSB:`RFC_FC_TRAIL_LSB];
  assign txCfg.leaderSymbol  =
    stateReg.frameCtl[`RFC_FC_LEAD_MSB:`RFC_FC_LEAD_LSB];
  assign txCfg.stopBit       = stateReg.typeB &&
    (stateReg.waitCtrl[`RFC_WC_STOP_MSB:`RFC_WC_STOP_LSB] != `RFC_STOP_NONE);
  assign txCfg.guardTimes    = (stateReg.typeB &&
    stateReg.waitCtrl[`RFC_WC_STOP_MSB:`RFC_WC_STOP_LSB] > `RFC_STOP_ONE) ?
    stateReg.waitCtrl[`RFC_WC_STOP_MSB:`RFC_WC_STOP_LSB] - `RFC_STOP_ONE
    : `RFC_STOP_NONE;

  // receive configuration
  assign rxCfg.parityCheck = stateReg.frameCtl[`RFC_FC_RX_PARITY];
  assign rxCfg.continuous  = stateReg.rxCtl[`RFC_RC_CONTINUOUS];
  assign rxCfg.eofTypeB    = stateReg.rxCtl[`RFC_RC_EOF_TYPE_B];
  assign rxCfg.eofCheck    = stateReg.rxCtl[`RFC_RC_EOF_TYPE_B] ||
                             (endSymbolBits != 2'b00);
  // codes below four are reserved and reported as not valid
  assign rxCfg.rateValid   = stateReg.rxCtl[`RFC_RC_RATE_MSB];
  assign rxCfg.rateSel     =
    stateReg.rxCtl[`RFC_RC_RATE_MSB-1:`RFC_RC_RATE_LSB];

  // events
  assign fifoWrite     = stateReg.fifoWrite;
  assign fifoData      = stateReg.fifoData;
  assign fifoFlush     = stateReg.fifoFlush;
  assign rxDone        = stateReg.rxDone;
  assign rxAutoStop    = stateReg.rxAutoStop;
  assign protoErr      = stateReg.protoErr;
  assign frameStartIrq = (stateReg.sofEn && stateReg.sofSeen) ||
                         (stateReg.subEn && stateReg.subSeen);

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  sequence s_disturb_hit;
    rxByteValid && frameErr && stateReg.rxCtl[`RFC_RC_DISTURB] &&
    stateReg.byteCount < `RFC_DISTURB_BYTES;
  endsequence

  sequence s_flushed;
    fifoFlush && !fifoWrite ##1 !rxDone;
  endsequence

  a_wait_reset: assert property ($past(rst) |->
    stateReg.waitCtrl == `RFC_WAIT_CTRL_RST)
    else $error("wait control reset value wrong");
  a_sof_sticky: assert property (sofDetect |=> stateReg.sofSeen)
    else $error("frame start flag not set");
  a_sub_sticky: assert property (subcarrierLive |=> stateReg.subSeen)
    else $error("subcarrier flag not set");
  a_sof_irq: assert property ((sofDetect && stateReg.sofEn &&
    !(wrFire && wrIdx == `RFC_IDX_START_DET)) |=> frameStartIrq)
    else $error("frame start interrupt missing");
  a_sub_irq: assert property ((subcarrierLive && stateReg.subEn &&
    !(wrFire && wrIdx == `RFC_IDX_START_DET)) |=> frameStartIrq)
    else $error("subcarrier interrupt missing");
  // half-bit ticks may end a short wait after one cycle, so carrier unit only
  a_tx_hold: assert property ((waitStart && waitValue != '0 &&
    !stateReg.waitCtrl[`RFC_WC_UNIT]) |->
    !txGrant ##1 !txGrant[*2])
    else $error("transmission granted during wait");
  a_rx_store: assert property ((rxByteValid && !disturbHit &&
    !rxFrameEnd && rxByte.complete) |=> fifoWrite &&
    fifoData == $past(rxByte.data))
    else $error("complete byte not stored");
  a_err_byte: assert property ((rxFrameEnd &&
    stateReg.rxCtl[`RFC_RC_CONTINUOUS]) |=> fifoWrite && !rxAutoStop &&
    fifoData == $past(errorReg))
    else $error("error byte not appended");
  a_auto_stop: assert property ((rxFrameEnd &&
    !stateReg.rxCtl[`RFC_RC_CONTINUOUS]) |=> rxAutoStop)
    else $error("receiver did not stop");
  a_emd_flush: assert property (s_disturb_hit |=> s_flushed)
    else $error("disturbance not discarded");
  a_guard_err: assert property ((rxGuardTooLong && stateReg.typeB &&
    stateReg.rxCtl[`RFC_RC_GUARD_CHECK]) |=> protoErr)
    else $error("guard time error missing");
  a_bus_answer: assert property ((wrFire ##1 !bready) |-> bvalid[*2])
    else $error("write answer dropped early");

endmodule // rfc_frame_timing

`default_nettype wire

// File: tb/rfc_card_model.sv
/* card-side model: drives the receive engine pins for one frame.
   assumes clk is the block clock and tasks start just after an edge. */
`default_nettype none
module rfc_card_model (
  // clock and receive engine pins
  input  wire logic             clk,
  output logic                  sofDetect,
  output logic                  subcarrierLive,
  output logic                  rxByteValid,
  output rfc_pkg::rfc_rx_byte_s rxByte,
  output logic                  rxFrameEnd
);
  timeunit 1ns;
  timeprecision 1ns;
  import rfc_pkg::*;
  initial
  begin
    {sofDetect, subcarrierLive, rxByteValid, rxFrameEnd} = '0;
    rxByte = '0;
  end
  task automatic setEnd(input logic v);
    rxFrameEnd <= v;
  endtask
  // frame end kept apart from the byte: the two must not coincide
  task automatic sendFrame(input logic [7:0] d);
    sofDetect <= 1'b1;
    subcarrierLive <= 1'b1;
    @(posedge clk);
    sofDetect <= 1'b0;
    rxByte <= '{data: d, parity: ~^d, complete: 1'b1};
    rxByteValid <= 1'b1;
    @(posedge clk);
    rxByteValid <= 1'b0;
    // released lines show the inverse, never a stale copy
    rxByte <= ~rxByte;
    subcarrierLive <= 1'b0;
    rxFrameEnd <= 1'b1;
    @(posedge clk);
    rxFrameEnd <= 1'b0;
  endtask
endmodule // rfc_card_model
`default_nettype wire

// File: tb/tb.sv
/* testbench top: host bus tasks, engine stimulus and checks.
   assumes the card model drives the receive engine pins. */
`default_nettype none
`define CHK(a, b) begin numChecks++; if ((a) !== (b)) begin nFail++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, a, b); end end
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import rfc_pkg::*;
  logic clk, rst, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, txRequest, txGrant, txFrameEnd;
  logic txByteValid, txParityBit, halfBitTick, sofDetect, subcarrierLive;
  logic crcEnable, rxByteValid, rxError, rxFrameEnd, rxGuardTooLong;
  logic fifoWrite, fifoFlush, rxDone, rxAutoStop, protoErr, frameStartIrq;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, endSymbolBits;
  logic [7:0]  txByte, errorReg, fifoData, rd8;
  logic [7:0]  fifoQ[$];
  rfc_tx_cfg_s  txCfg;
  rfc_rx_cfg_s  rxCfg;
  rfc_rx_byte_s rxByte;
  int nFail = 0, numChecks = 0, nStop = 0;
  // two clocks per carrier unit keeps long waits short
  rfc_frame_timing #(.UNIT_CYC(2)) uut (.*);
  rfc_card_model card (.*);
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) if (fifoWrite) fifoQ.push_back(fifoData);
  always @(posedge clk) if (rxAutoStop) nStop++;
  task automatic finish_test();
    $display("checks %0d mismatches %0d", numChecks, nFail);
    if (nFail == 0 && numChecks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic waitHi(ref logic s);
    int i;
    @(posedge clk);
    for (i = 0; i < 1000 && s !== 1'b1; i++)
      @(posedge clk);
    nFail += (s !== 1'b1);
    if (s !== 1'b1)
      finish_test();
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    awaddr <= {2'b00, idx, 2'b00};
    wdata <= {24'h0, d};
    {awvalid, wvalid, bready} <= 3'h7;
    waitHi(awready);
    {awvalid, wvalid} <= 2'h0;
    waitHi(bvalid);
    bready <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] idx, input logic [1:0] r);
    araddr <= {2'b00, idx, 2'b00};
    {arvalid, rready} <= 2'h3;
    waitHi(arready);
    arvalid <= 1'b0;
    waitHi(rvalid);
    rd8 = rdata[7:0];
    `CHK(rresp, r)
    rready <= 1'b0;
    @(posedge clk);
  endtask
  task automatic s_tx();
    rd(8'h31, 2'b00);
    `CHK(rd8, 8'hc0)
    rd(8'h20, 2'b10);
    wr(8'h33, 8'h8e);
    `CHK(txCfg.trailerSymbol, 2'h3)
    `CHK(txCfg.leaderSymbol, 2'h2)
    `CHK(txCfg.parityAppend, 1'b1)
    {txByte, txByteValid, txRequest} <= {8'h03, 2'b10};
    @(posedge clk);
    {txByteValid, txRequest} <= 2'b01;
    @(negedge clk);
    `CHK(txGrant, 1'b1)
    @(posedge clk);
    `CHK(txParityBit, 1'b1)
    wr(8'h40, 8'h01);
    wr(8'h31, 8'h05);
    `CHK({txCfg.stopBit, txCfg.guardTimes}, 4'hc)
    wr(8'h35, 8'h10);
    rxGuardTooLong <= 1'b1;
    @(posedge clk);
    rxGuardTooLong <= 1'b0;
    @(negedge clk);
    `CHK(protoErr, 1'b1)
    @(posedge clk);
    wr(8'h35, 8'h26);
    `CHK({rxCfg.eofTypeB, rxCfg.rateValid, rxCfg.rateSel}, 4'he)
    endSymbolBits <= 2'h1;
    wr(8'h35, 8'h06);
    `CHK(rxCfg.eofCheck, 1'b1)
    endSymbolBits <= 2'h0;
    @(posedge clk);
    `CHK(rxCfg.eofCheck, 1'b0)
  endtask
  // counts the cycles in which a standing request is held off
  task automatic s_wait(input logic [7:0] c, lo, input logic rx, input int e);
    int n;
    n = 0;
    wr(8'h32, lo);
    wr(8'h31, c);
    if (rx) card.setEnd(1'b1);
    else txFrameEnd <= 1'b1;
    // grant is looked at mid-cycle, where it has settled
    repeat (600)
    begin
      @(negedge clk);
      n += (txGrant !== 1'b1);
      @(posedge clk);
      card.setEnd(1'b0);
      txFrameEnd <= 1'b0;
    end
    `CHK(n, e)
  endtask
  task automatic s_rx();
    nStop = 0;
    wr(8'h34, 8'h24);
    wr(8'h35, 8'h40);
    card.sendFrame(8'h3c);
    repeat (2) @(posedge clk);
    `CHK({fifoQ.size(), fifoQ[0], fifoQ[1]}, {32'd2, 16'h3c5a})
    `CHK(nStop, 0)
    rd(8'h34, 2'b00);
    `CHK(rd8, 8'h36)
    `CHK(frameStartIrq, 1'b1)
    wr(8'h34, 8'h04);
    rd(8'h34, 2'b00);
    `CHK({rd8, frameStartIrq}, 9'h008)
    card.sendFrame(8'h00);
    `CHK(frameStartIrq, 1'b1)
  endtask
  initial
  begin
    {awvalid, wvalid, bready, arvalid, rready, txFrameEnd, txByteValid} = '0;
    {halfBitTick, crcEnable, rxError, rxGuardTooLong, endSymbolBits} = '0;
    {awaddr, araddr, wdata, txByte} = '0;
    {rst, txRequest, wstrb, errorReg} = {2'b11, 4'hf, 8'h5a};
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    s_tx();
    s_wait(8'h00, 8'h03, 1'b0, 7);
    s_wait(8'h08, 8'h03, 1'b0, 519);
    s_wait(8'h80, 8'h03, 1'b0, 0);
    s_wait(8'h80, 8'h03, 1'b1, 7);
    s_rx();
    finish_test();
  end
endmodule // tb
`default_nettype wire
